/* File: logic/cprs_defs.svh */
// Constants for the card punch row setup block.
// Assumes inclusion by the package and the design modules only.
`ifndef CPRS_DEFS_SVH
`define CPRS_DEFS_SVH
`define CPRS_NUM_COLUMNS    45
`define CPRS_NUM_LINES      10
`define CPRS_NUM_GROUPS     5
`define CPRS_NUM_ROWS       12
`define CPRS_LAST_GROUP_LINES 5
`define CPRS_FIFO_DEPTH     8
`define CPRS_CAM_PULSE_NS   15000
`define CPRS_CLK_PERIOD_NS  8
`define CPRS_CAM_PULSE_CYC  ((`CPRS_CAM_PULSE_NS)/(`CPRS_CLK_PERIOD_NS))
`endif

/* File: logic/cprs_pkg.sv */
// Types for the card punch row setup block.
// Assumes cprs_defs.svh is available on the include path.
`include "cprs_defs.svh"
package cprs_pkg;
  typedef enum logic [2:0] {
    CPRS_IDLE  = 3'h0,
    CPRS_SHIFT = 3'h1,
    CPRS_LOAD  = 3'h3,
    CPRS_ROWON = 3'h2,
    CPRS_CLEAR = 3'h6,
    CPRS_PUNCH = 3'h7
  } cprs_state_type;
endpackage

/* File: logic/cprs_fifo.sv */
// Parameterised word FIFO with valid and ready on both sides.
// Assumes a single clock and an active-low asynchronous reset.
`timescale 1ns/100ps
module cprs_fifo #(
  parameter int WIDTH = 1,
  parameter int DEPTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [WIDTH-1:0] i_data,
  input  wire logic             i_valid,
  output logic                  o_ready,
  output logic      [WIDTH-1:0] o_data,
  output logic                  o_valid,
  input  wire logic             i_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW-1:0]    next_wr_ptr;
  logic [AW-1:0]    next_rd_ptr;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  assign o_ready = (count != (AW+1)'(DEPTH));
  assign o_valid = (count != '0);
  assign push    = i_valid && o_ready;
  assign pop     = o_valid && i_ready;
  assign o_data  = mem[rd_ptr];

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_wr_ptr = (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
    end
    if (pop) begin
      next_rd_ptr = (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  // Storage needs no reset; only words counted as valid are ever read.
  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_data;
    end
  end
endmodule

/* File: logic/cprs_top.sv */
// Card punch row setup: serial data to column latches, row lines, cams.
// Assumes the drum buffer streams bits over valid/ready and that cam
// contacts arrive asynchronously as active-low closures.
//
// Function
// - Line s under group g selects column 10*(g-2)+s; group 6 uses five.
// - A high parallel shift line requests a hole in its selected column.
// - A column latch sets only when line and group drivers are both active.
// - A set column latch holds its column line until cleared.
// - After each row's groups are loaded, clear all column latches.
// - At most one of twelve row lines is active at a time.
// - Row lines also step one after another during card sensing.
// - After all rows, a punch pulse fires all energised actuators at once.
// - Each cam closure yields one short pulse, not a level.
// - A latch accepts its set request at any time in the row interval.
// - Data shifts serially into a ten-bit register, then loads in parallel.
`timescale 1ns/100ps
`include "cprs_defs.svh"
module cprs_top
  import cprs_pkg::*;
(
  input  wire logic                         I_SYS_CLK,
  input  wire logic                         I_RSTN,
  input  wire logic                         I_DATA_BIT,
  input  wire logic                         I_DATA_VALID,
  output logic                              O_DATA_READY,
  input  wire logic                         I_SENSE_CAM_N,
  input  wire logic                         I_PUNCH_CAM_N,
  input  wire logic                         I_SENSE_STEP,
  output logic                              O_SENSE_START,
  output logic                              O_PUNCH_START,
  output logic [`CPRS_NUM_COLUMNS-1:0]      O_COLUMN_LINE,
  output logic [`CPRS_NUM_ROWS-1:0]         O_ROW_LINE,
  output logic                              O_PUNCH_FIRE,
  output logic                              O_BUSY
);
  localparam int NL = `CPRS_NUM_LINES;
  localparam int NG = `CPRS_NUM_GROUPS;
  localparam int NR = `CPRS_NUM_ROWS;
  localparam int NC = `CPRS_NUM_COLUMNS;
  localparam int PW = (`CPRS_CAM_PULSE_CYC < 1) ? 1 : `CPRS_CAM_PULSE_CYC;

  ////////////////////////////////////////////////////////////////////////
  // Cam pulse shaper: synchronise, detect closure, stretch to 15 us.

  logic [1:0]  sense_sync;
  logic [1:0]  punch_sync;
  logic        sense_prev;
  logic        punch_prev;
  logic [11:0] sense_cnt;
  logic [11:0] punch_cnt;
  logic [11:0] next_sense_cnt;
  logic [11:0] next_punch_cnt;
  logic        sense_edge;
  logic        punch_edge;

  // Cam closure is active low; sync flop 0 feeds only flop 1.
  assign sense_edge = !sense_sync[1] && sense_prev;
  assign punch_edge = !punch_sync[1] && punch_prev;

  always_comb begin
    next_sense_cnt = (sense_cnt != '0) ? sense_cnt - 1'b1 : '0;
    next_punch_cnt = (punch_cnt != '0) ? punch_cnt - 1'b1 : '0;
    if (sense_edge) begin
      next_sense_cnt = 12'(PW);
    end
    if (punch_edge) begin
      next_punch_cnt = 12'(PW);
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      sense_sync <= 2'h3;
      punch_sync <= 2'h3;
      sense_prev <= 1'b1;
      punch_prev <= 1'b1;
      sense_cnt  <= 12'h000;
      punch_cnt  <= 12'h000;
    end else begin
      sense_sync <= {sense_sync[0], I_SENSE_CAM_N};
      punch_sync <= {punch_sync[0], I_PUNCH_CAM_N};
      sense_prev <= sense_sync[1];
      punch_prev <= punch_sync[1];
      sense_cnt  <= next_sense_cnt;
      punch_cnt  <= next_punch_cnt;
    end
  end

  // A level-held closure gives one pulse only, as the edge fires once.
  assign O_SENSE_START = (sense_cnt != '0);
  assign O_PUNCH_START = (punch_cnt != '0);

  ////////////////////////////////////////////////////////////////////////
  // Data FIFO between drum buffer and shift register.

  logic fifo_bit;
  logic fifo_valid;
  logic fifo_ready;

  cprs_fifo #(
    .WIDTH (1),
    .DEPTH (`CPRS_FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (I_SYS_CLK),
    .i_rstn  (I_RSTN),
    .i_data  (I_DATA_BIT),
    .i_valid (I_DATA_VALID),
    .o_ready (O_DATA_READY),
    .o_data  (fifo_bit),
    .o_valid (fifo_valid),
    .i_ready (fifo_ready)
  );

  ////////////////////////////////////////////////////////////////////////
  // Sequencer for punch setup and row stepping for sensing.

  cprs_state_type    state;
  cprs_state_type    next_state;
  logic [NL-1:0]     shift_reg;
  logic [NL-1:0]     next_shift_reg;
  logic [3:0]        bit_cnt;
  logic [3:0]        next_bit_cnt;
  logic [2:0]        group;
  logic [2:0]        next_group;
  logic [3:0]        row;
  logic [3:0]        next_row;
  logic              row_on;
  logic              next_row_on;
  logic              sensing;
  logic              next_sensing;
  logic [1:0]        step_sync;
  logic              step_prev;
  logic              step_edge;
  logic              load_pulse;
  logic              clear_pulse;
  logic              fire;
  logic              next_fire;

  assign step_edge  = step_sync[1] && !step_prev;
  assign fifo_ready = (state == CPRS_SHIFT);
  assign load_pulse = (state == CPRS_LOAD);
  assign clear_pulse = (state == CPRS_CLEAR);

  always_comb begin
    next_state     = state;
    next_shift_reg = shift_reg;
    next_bit_cnt   = bit_cnt;
    next_group     = group;
    next_row       = row;
    next_row_on    = row_on;
    next_sensing   = sensing;
    next_fire      = 1'b0;
    case (state)
      CPRS_IDLE: begin
        if (sense_edge) begin
          next_sensing = 1'b1;
          next_row     = 4'h0;
          next_row_on  = 1'b1;
        end else if (sensing && step_edge) begin
          // Rows step one after another for sensing.
          if (row == 4'(NR-1)) begin
            next_sensing = 1'b0;
            next_row_on  = 1'b0;
            next_row     = 4'h0;
          end else begin
            next_row = row + 1'b1;
          end
        end else if (punch_edge) begin
          next_sensing = 1'b0;
          next_row_on  = 1'b0;
          next_row     = 4'h0;
          next_group   = 3'h0;
          next_bit_cnt = 4'h0;
          next_state   = CPRS_SHIFT;
        end
      end
      CPRS_SHIFT: begin
        if (fifo_valid) begin
          // Serial load into the ten-bit register.
          next_shift_reg = {shift_reg[NL-2:0], fifo_bit};
          if (bit_cnt == 4'(NL-1)) begin
            next_bit_cnt = 4'h0;
            next_state   = CPRS_LOAD;
          end else begin
            next_bit_cnt = bit_cnt + 1'b1;
          end
        end
      end
      CPRS_LOAD: begin
        // One group per ten-bit load; only one group is live.
        if (group == 3'(NG-1)) begin
          next_group = 3'h0;
          next_state = CPRS_ROWON;
        end else begin
          next_group = group + 1'b1;
          next_state = CPRS_SHIFT;
        end
      end
      CPRS_ROWON: begin
        next_row_on = 1'b1;
        next_state  = CPRS_CLEAR;
      end
      CPRS_CLEAR: begin
        next_row_on = 1'b0;
        if (row == 4'(NR-1)) begin
          next_row   = 4'h0;
          next_state = CPRS_PUNCH;
        end else begin
          next_row   = row + 1'b1;
          next_state = CPRS_SHIFT;
        end
      end
      CPRS_PUNCH: begin
        // All locked actuators fire together; release is mechanical.
        next_fire  = 1'b1;
        next_state = CPRS_IDLE;
      end
      default: begin
        next_state = CPRS_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      state     <= CPRS_IDLE;
      shift_reg <= 10'h000;
      bit_cnt   <= 4'h0;
      group     <= 3'h0;
      row       <= 4'h0;
      row_on    <= 1'b0;
      sensing   <= 1'b0;
      fire      <= 1'b0;
      step_sync <= 2'h0;
      step_prev <= 1'b0;
    end else begin
      state     <= next_state;
      shift_reg <= next_shift_reg;
      bit_cnt   <= next_bit_cnt;
      group     <= next_group;
      row       <= next_row;
      row_on    <= next_row_on;
      sensing   <= next_sensing;
      fire      <= next_fire;
      step_sync <= {step_sync[0], I_SENSE_STEP};
      step_prev <= step_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Distribution matrix and column latches.

  logic [NL-1:0] line_drv;
  logic [NG-1:0] group_drv;
  logic [NC-1:0] col_latch;
  logic [NC-1:0] next_col_latch;
  logic [NC-1:0] col_set;

  // First bit shifted in lands on the first line.
  always_comb begin
    for (int s = 0; s < NL; s++) begin
      line_drv[s] = load_pulse && shift_reg[NL-1-s];
    end
  end

  // One-hot group select.
  always_comb begin
    for (int g = 0; g < NG; g++) begin
      group_drv[g] = load_pulse && (group == 3'(g));
    end
  end

  // Column index c maps to line c mod 10 and group c div 10.
  genvar c;
  generate
    for (c = 0; c < NC; c++) begin : g_col
      assign col_set[c] = line_drv[c % NL] && group_drv[c / NL];
    end
  endgenerate

  always_comb begin
    next_col_latch = col_latch;
    if (clear_pulse) begin
      next_col_latch = '0;
    end
    // Set is taken in any cycle of the row interval.
    next_col_latch = next_col_latch | col_set;
  end

  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      col_latch <= '0;
    end else begin
      col_latch <= next_col_latch;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs.

  always_comb begin
    for (int r = 0; r < NR; r++) begin
      O_ROW_LINE[r] = row_on && (row == 4'(r));
    end
  end

  assign O_COLUMN_LINE = col_latch;
  assign O_PUNCH_FIRE  = fire;
  assign O_BUSY        = (state != CPRS_IDLE);
endmodule

/* File: bench/cprs_monitor.sv */
// Checker on the ports of the card punch row setup top.
// Assumes a bind from the bench top file; one clock domain.
`timescale 1ns/100ps
module cprs_monitor (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RSTN,
  input wire logic        I_PUNCH_CAM_N,
  input wire logic        O_PUNCH_START,
  input wire logic        O_SENSE_START,
  input wire logic [44:0] O_COLUMN_LINE,
  input wire logic [11:0] O_ROW_LINE,
  input wire logic        O_PUNCH_FIRE,
  input wire logic        O_BUSY
);
  ////////////////////////////////////////
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RSTN);
  logic [11:0] p_cnt;
  logic [11:0] s_cnt;
  logic [11:0] next_p_cnt;
  logic [11:0] next_s_cnt;
  // Counting high samples checks the pulse length to the exact cycle.
  always_comb begin
    next_p_cnt = O_PUNCH_START ? p_cnt + 12'h001 : 12'h000;
    next_s_cnt = O_SENSE_START ? s_cnt + 12'h001 : 12'h000;
  end
  always_ff @(posedge I_SYS_CLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      p_cnt <= 12'h000;
      s_cnt <= 12'h000;
    end else begin
      p_cnt <= next_p_cnt;
      s_cnt <= next_s_cnt;
    end
  end
  AST_ROW_ONEHOT: assert property ($onehot0(O_ROW_LINE))
    else $error("Several row lines active.");
  AST_ROW_BRIEF: assert property (O_BUSY && |O_ROW_LINE
    |=> O_ROW_LINE == 12'h000) else $error("Setup row line held.");
  AST_COL_HOLD: assert property (|O_COLUMN_LINE |=>
    O_COLUMN_LINE == 45'h0 ||
    (O_COLUMN_LINE & $past(O_COLUMN_LINE)) == $past(O_COLUMN_LINE))
    else $error("Column latch dropped alone.");
  AST_COL_IDLE: assert property (!O_BUSY |->
    O_COLUMN_LINE == 45'h0) else $error("Latch set while idle.");
  AST_FIRE_ONE: assert property (O_PUNCH_FIRE |=> !O_PUNCH_FIRE)
    else $error("Punch fire longer than one cycle.");
  AST_FIRE_CLR: assert property (O_PUNCH_FIRE |->
    O_COLUMN_LINE == 45'h0 && O_ROW_LINE == 12'h000)
    else $error("Punch fire with lines active.");
  AST_P_LEN: assert property ($fell(O_PUNCH_START) |->
    p_cnt == 12'h753) else $error("Punch start length wrong.");
  AST_S_LEN: assert property ($fell(O_SENSE_START) |->
    s_cnt == 12'h753) else $error("Sense start length wrong.");
  AST_P_CAUSE: assert property ($rose(O_PUNCH_START) |->
    !$past(I_PUNCH_CAM_N, 3)) else $error("Punch start without cam.");
endmodule

/* File: bench/cprs_punch_model.sv */
// Actuator matrix on the far side of the row and column lines.
// Assumes one-hot row lines and registered column lines.
`timescale 1ns/100ps
module cprs_punch_model (
  input  wire logic             i_clk,
  input  wire logic             i_rstn,
  input  wire logic [11:0]      i_row,
  input  wire logic [44:0]      i_col,
  input  wire logic             i_fire,
  output logic      [11:0][44:0] o_card,
  output logic      [7:0]       o_fires
);
  ////////////////////////////////////////
  logic [11:0][44:0] locked;
  // Actuators lock mechanically, so holes stay after the row line drops.
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      locked  <= '0;
      o_card  <= '0;
      o_fires <= 8'h00;
    end else begin
      for (int r = 0; r < 12; r++) begin
        if (i_row[r]) begin
          locked[r] <= locked[r] | i_col;
        end
      end
      if (i_fire) begin
        o_card  <= locked;
        locked  <= '0;
        o_fires <= o_fires + 8'h01;
      end
    end
  end
endmodule

/* File: bench/tb_top.sv */
// Self-checking bench for the card punch row setup block.
// Assumes design files, actuator model and checker compiled first.
`timescale 1ns/100ps
module tb_top;
  ////////////////////////////////////////
  logic              clk;
  logic              rstn;
  logic              d_bit;
  logic              d_valid;
  logic              d_ready;
  logic              s_cam_n;
  logic              p_cam_n;
  logic              s_step;
  logic              s_start;
  logic              p_start;
  logic [44:0]       col;
  logic [11:0]       row;
  logic              fire;
  logic              busy;
  logic [11:0][44:0] card;
  logic [7:0]        fires;
  int                seed = 65982;
  int                failures = 0;
  int                n_checks = 0;
  cprs_top cprs_top_i (
    .I_SYS_CLK(clk), .I_RSTN(rstn), .I_DATA_BIT(d_bit),
    .I_DATA_VALID(d_valid), .O_DATA_READY(d_ready),
    .I_SENSE_CAM_N(s_cam_n), .I_PUNCH_CAM_N(p_cam_n),
    .I_SENSE_STEP(s_step), .O_SENSE_START(s_start),
    .O_PUNCH_START(p_start), .O_COLUMN_LINE(col), .O_ROW_LINE(row),
    .O_PUNCH_FIRE(fire), .O_BUSY(busy));
  cprs_punch_model cprs_punch_model_i (
    .i_clk(clk), .i_rstn(rstn), .i_row(row), .i_col(col),
    .i_fire(fire), .o_card(card), .o_fires(fires));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [44:0] seen,
                     input logic [44:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic hang();
    failures++;
    results();
  endtask
  // Random gaps in valid exercise the FIFO with an idle source.
  task automatic send_bit(input logic b);
    int w = 0;
    d_bit = b;
    d_valid = 1'b1;
    while (d_ready !== 1'b1) begin
      tick(1);
      w++;
      if (w > 3000) hang();
    end
    tick(1);
    if ($random(seed) % 4 == 0) begin
      d_valid = 1'b0;
      tick(1);
    end
  endtask
  function automatic logic [44:0] exp_row(input logic [599:0] b,
                                          input int r);
    logic [44:0] e = '0;
    for (int g = 0; g < 5; g++)
      for (int s = 0; s < 10; s++)
        if (g < 4 || s < 5) e[10*g+s] = b[50*r+10*g+s];
    return e;
  endfunction
  // Kind 0 is random data, 1 all holes, 2 no holes.
  task automatic run_card(input int kind);
    logic [599:0] b;
    int w = 0;
    for (int i = 0; i < 600; i++) begin
      b[i] = (kind == 0) ? 1'($random(seed)) : (kind == 1);
    end
    for (int i = 0; i < 600; i++) begin
      if (i == 8) begin
        chk("ready full", {44'h0, d_ready}, 45'h0);
        p_cam_n = 1'b0;
      end
      if (i == 16) begin
        chk("punch start", {44'h0, p_start}, 45'h1);
      end
      send_bit(b[i]);
    end
    d_valid = 1'b0;
    p_cam_n = 1'b1;
    while (busy !== 1'b0) begin
      tick(1);
      w++;
      if (w > 3000) hang();
    end
    tick(2);
    chk("fires", {37'h0, fires}, 45'(kind + 1));
    for (int r = 0; r < 12; r++) begin
      chk("holes", card[r], exp_row(b, r));
    end
    $display("card test %0d done", kind);
    tick(1900);
  endtask
  task automatic run_sense();
    s_cam_n = 1'b0;
    tick(6);
    chk("sense start", {44'h0, s_start}, 45'h1);
    for (int k = 0; k < 12; k++) begin
      chk("sense row", {33'h0, row}, 45'h1 << k);
      s_step = 1'b1;
      tick(4);
      s_step = 1'b0;
      tick(4);
    end
    chk("sense end", {33'h0, row}, 45'h0);
    s_cam_n = 1'b1;
    tick(1900);
    $display("sense test done");
  endtask
  initial begin
    rstn = 1'b0;
    d_bit = 1'b0;
    d_valid = 1'b0;
    s_cam_n = 1'b1;
    p_cam_n = 1'b1;
    s_step = 1'b0;
    tick(4);
    rstn = 1'b1;
    tick(3);
    for (int k = 0; k < 3; k++) begin
      run_card(k);
    end
    run_sense();
    results();
  end
endmodule
bind cprs_top cprs_monitor cprs_monitor_i (
  .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_PUNCH_CAM_N(I_PUNCH_CAM_N),
  .O_PUNCH_START(O_PUNCH_START), .O_SENSE_START(O_SENSE_START),
  .O_COLUMN_LINE(O_COLUMN_LINE), .O_ROW_LINE(O_ROW_LINE),
  .O_PUNCH_FIRE(O_PUNCH_FIRE), .O_BUSY(O_BUSY));
